// >>> src/warf_map.svh
`ifndef WARF_MAP_SVH
`define WARF_MAP_SVH

// ********************************************************************
// Register offsets.
// ********************************************************************
`define WARF_OFF_CAUSE     8'h00
`define WARF_OFF_CTRL      8'h04
`define WARF_OFF_COUNT     8'h08

// ********************************************************************
// Reset-cause status field positions.
// ********************************************************************
`define WARF_BIT_POWERON   0
`define WARF_BIT_EXTPIN    1
`define WARF_BIT_BROWNOUT  2
`define WARF_BIT_WATCHDOG  3
`define WARF_BIT_TESTPORT  4
`define WARF_BIT_USBCORE   5
`define WARF_CAUSE_W       6
`define WARF_CAUSE_RST     6'h01

// ********************************************************************
// Watchdog control field positions.
// ********************************************************************
`define WARF_BIT_IFLAG     7
`define WARF_BIT_IEN       6
`define WARF_BIT_PSC3      5
`define WARF_BIT_CHG       4
`define WARF_BIT_REN       3
`define WARF_PSC_LO_HI     2

// ********************************************************************
// Timing.
// ********************************************************************
`define WARF_CHG_WINDOW    3'h4
`define WARF_BASE_CYCLES   2048
`define WARF_PSC_MAX       4'h9
`define WARF_TMO_MIN_MS    16
`define WARF_TMO_MAX_MS    8000
`define WARF_BROWNOUT_OFF  3'h7

`endif

// >>> src/warf_pkg.sv
package warf_pkg;

	typedef enum logic [1:0] {
		WARF_STOPPED,
		WARF_IRQ_MODE,
		WARF_RESET_MODE,
		WARF_BOTH_MODE
	} warf_mode_t;

endpackage

// >>> src/warf_top.sv
`timescale 1ns/1ps
`include "warf_map.svh"

// How it works
// - Watchdog expiry in reset mode gives a one-cycle reset; delay starts at its end.
// - USB bus reset with core-reset option resets the core, USB stays attached.
// - Cause register bits 7..6 read zero; software must not write ones there.
// - Bit 5 flags a USB-caused core reset; power-on or written zero clears it.
// - Bit 4 flags a test-port reset; power-on or written zero clears it.
// - Bit 3 flags a watchdog reset; power-on or written zero clears it.
// - Bit 2 flags a brown-out reset; power-on or written zero clears it.
// - Bit 1 flags an external pin reset; power-on or written zero clears it.
// - Bit 0 is set by power-on and cleared only by a written zero.
// - Bandgap is on only for brown-out fuse, comparator select or ADC enable.
// - Counter advances on separate oscillator ticks and acts at the time-out value.
// - Restart command zeroes the counter; software must restart before time-out.
// - Interrupt mode expiry raises an interrupt request that can also wake.
// - Reset mode expiry resets the device.
// - Combined mode: first expiry interrupts, then a later expiry resets.
// - Always-on fuse forces reset mode: reset enable one, interrupt enable zero.
// - A change opens by writing change enable and reset enable both one.
// - Within four cycles one write with change enable clear sets the guarded fields.
// - Prescaler codes give periods from 16 ms to 8 s.
// - The watchdog stays enabled after a watchdog reset.
// - While the watchdog flag is set, reset enable reads and stays one.
// - Change enable clears itself four cycles after being written one.
// - Interrupt flag sets on time-out in interrupt or combined mode; vector or written one clears it.
module warf_top #(
	parameter int unsigned P_BASE_CYCLES = `WARF_BASE_CYCLES,
	parameter int unsigned P_CNT_W       = 21
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [31:0] PRDATA,
	input  wire logic        I_OSC_TICK,
	input  wire logic        I_WDOG_RESTART,
	input  wire logic        I_VECTOR_ACK,
	input  wire logic        I_ALWAYS_ON_FUSE,
	input  wire logic [2:0]  I_BROWNOUT_LEVEL_FUSE,
	input  wire logic        I_COMPARATOR_BANDGAP_SELECT,
	input  wire logic        I_ADC_EN,
	input  wire logic        I_EXT_PIN_RST,
	input  wire logic        I_BROWNOUT_RST,
	input  wire logic        I_TEST_PORT_RST,
	input  wire logic        I_USB_EN,
	input  wire logic        I_USB_CORE_RST_EN,
	input  wire logic        I_USB_BUS_RST,
	output logic             O_WDOG_RST,
	output logic             O_DELAY_START,
	output logic             O_USB_CORE_RST,
	output logic             O_USB_KEEP_ATTACHED,
	output logic             O_IRQ,
	output logic             O_BANDGAP_EN
);

	// ****************************************************************
	// Register bus decode.
	// ****************************************************************
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	logic                   setup_ph;
	logic                   wr_acc;
	logic                   wr_cause;
	logic                   wr_ctrl;
	logic                   mapped;
	logic [31:0]            rd_word;
	logic [31:0]            prdata_r;
	logic                   pslverr_r;

	assign setup_ph = PSEL & ~PENABLE;
	assign wr_acc   = PSEL & PENABLE & PWRITE;
	assign mapped   = addr_hit(PADDR, `WARF_OFF_CAUSE) | addr_hit(PADDR, `WARF_OFF_CTRL) |
	                  addr_hit(PADDR, `WARF_OFF_COUNT);
	assign wr_cause = wr_acc & addr_hit(PADDR, `WARF_OFF_CAUSE);
	assign wr_ctrl  = wr_acc & addr_hit(PADDR, `WARF_OFF_CTRL);

	// ****************************************************************
	// Reset-cause flags.
	// ****************************************************************
	logic [`WARF_CAUSE_W-1:0] cause_r;
	logic [`WARF_CAUSE_W-1:0] cause_nxt;
	logic [`WARF_CAUSE_W-1:0] cause_ev;
	logic                     usb_rst;
	logic                     wdog_rst;

	assign usb_rst = I_USB_EN & I_USB_CORE_RST_EN & I_USB_BUS_RST;

	assign cause_ev[`WARF_BIT_POWERON]  = 1'b0;
	assign cause_ev[`WARF_BIT_EXTPIN]   = I_EXT_PIN_RST;
	assign cause_ev[`WARF_BIT_BROWNOUT] = I_BROWNOUT_RST;
	assign cause_ev[`WARF_BIT_WATCHDOG] = wdog_rst;
	assign cause_ev[`WARF_BIT_TESTPORT] = I_TEST_PORT_RST;
	assign cause_ev[`WARF_BIT_USBCORE]  = usb_rst;

	// A new reset cause beats a written zero in the same cycle, so no cause is lost.
	genvar gi;
	generate
		for (gi = 0; gi < `WARF_CAUSE_W; gi++) begin : g_cause
			assign cause_nxt[gi] = cause_ev[gi] | (cause_r[gi] & ~(wr_cause & ~PWDATA[gi]));
		end
	endgenerate

	// ****************************************************************
	// Watchdog control.
	// ****************************************************************
	logic                 ien_r;
	logic                 ien_nxt;
	logic                 ren_r;
	logic                 ren_nxt;
	logic                 iflag_r;
	logic                 iflag_nxt;
	logic [3:0]           psc_r;
	logic [3:0]           psc_nxt;
	logic [3:0]           psc_wr;
	logic [2:0]           chg_cnt_r;
	logic [2:0]           chg_cnt_nxt;
	logic                 in_win;
	logic                 open_seq;
	logic                 timed_wr;
	logic                 ren_eff;
	logic                 ien_eff;
	logic                 wdog_flag;
	warf_pkg::warf_mode_t mode;
	logic                 irq_set;

	assign wdog_flag = cause_r[`WARF_BIT_WATCHDOG];
	assign psc_wr   = {PWDATA[`WARF_BIT_PSC3], PWDATA[`WARF_PSC_LO_HI:0]};
	assign in_win   = (chg_cnt_r != 3'h0);
	assign open_seq = wr_ctrl & PWDATA[`WARF_BIT_CHG] & PWDATA[`WARF_BIT_REN];
	assign timed_wr = wr_ctrl & in_win & ~PWDATA[`WARF_BIT_CHG];

	assign chg_cnt_nxt = open_seq ? `WARF_CHG_WINDOW :
	                     in_win   ? chg_cnt_r - 3'h1 : 3'h0;

	assign psc_nxt = timed_wr ? psc_wr : psc_r;

	// Reset enable may always be raised; lowering it needs the open window.
	assign ren_nxt = (wdog_flag | I_ALWAYS_ON_FUSE) ? 1'b1 :
	                 timed_wr ? PWDATA[`WARF_BIT_REN] :
	                 (ren_r | (wr_ctrl & PWDATA[`WARF_BIT_REN]));

	assign ien_nxt = I_ALWAYS_ON_FUSE ? 1'b0 :
	                 wr_ctrl ? PWDATA[`WARF_BIT_IEN] :
	                 (I_VECTOR_ACK & (mode == warf_pkg::WARF_BOTH_MODE)) ? 1'b0 : ien_r;

	assign iflag_nxt = irq_set |
	                   (iflag_r & ~I_VECTOR_ACK & ~(wr_ctrl & PWDATA[`WARF_BIT_IFLAG]));

	assign ren_eff = ren_r | wdog_flag | I_ALWAYS_ON_FUSE;
	assign ien_eff = ien_r & ~I_ALWAYS_ON_FUSE;
	assign mode    = warf_pkg::warf_mode_t'({ren_eff, ien_eff});

	// ****************************************************************
	// Time-out counter.
	// ****************************************************************
	logic [P_CNT_W-1:0] cnt_r;
	logic [P_CNT_W-1:0] cnt_nxt;
	logic [P_CNT_W-1:0] limit_m1;
	logic [3:0]         psc_eff;
	logic               running;
	logic               expire;
	logic               rst_set;

	// Reserved codes fall back to the longest period rather than a surprise short one.
	assign psc_eff  = (psc_r > `WARF_PSC_MAX) ? `WARF_PSC_MAX : psc_r;
	assign limit_m1 = P_CNT_W'((P_BASE_CYCLES << psc_eff) - 1);
	assign running  = (mode != warf_pkg::WARF_STOPPED);
	assign expire   = running & I_OSC_TICK & (cnt_r >= limit_m1);

	assign cnt_nxt = (I_WDOG_RESTART | expire | ~running) ? '0 :
	                 I_OSC_TICK ? cnt_r + P_CNT_W'(1) : cnt_r;

	always_comb begin
		irq_set = 1'b0;
		rst_set = 1'b0;
		unique case (mode)
			warf_pkg::WARF_STOPPED: begin
			end
			warf_pkg::WARF_IRQ_MODE: begin
				irq_set = expire;
			end
			warf_pkg::WARF_RESET_MODE: begin
				rst_set = expire;
			end
			warf_pkg::WARF_BOTH_MODE: begin
				irq_set = expire & ~iflag_r;
				rst_set = expire & iflag_r;
			end
		endcase
	end

	assign wdog_rst = O_WDOG_RST;

	// ****************************************************************
	// Read data.
	// ****************************************************************
	logic [7:0] ctrl_rd;

	assign ctrl_rd = {iflag_r, ien_eff, psc_r[3], in_win, ren_eff, psc_r[2:0]};
	assign rd_word = addr_hit(PADDR, `WARF_OFF_CAUSE) ? {24'h0, 2'h0, cause_r} :
	                 addr_hit(PADDR, `WARF_OFF_CTRL)  ? {24'h0, ctrl_rd} :
	                 addr_hit(PADDR, `WARF_OFF_COUNT) ? 32'(cnt_r) : 32'h0;

	// ****************************************************************
	// Registers.
	// ****************************************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			cause_r   <= `WARF_CAUSE_RST;
			ien_r     <= 1'b0;
			ren_r     <= 1'b0;
			iflag_r   <= 1'b0;
			psc_r     <= 4'h0;
			chg_cnt_r <= 3'h0;
			cnt_r     <= '0;
		end else begin
			cause_r   <= cause_nxt;
			ien_r     <= ien_nxt;
			ren_r     <= ren_nxt;
			iflag_r   <= iflag_nxt;
			psc_r     <= psc_nxt;
			chg_cnt_r <= chg_cnt_nxt;
			cnt_r     <= cnt_nxt;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_WDOG_RST          <= 1'b0;
			O_DELAY_START       <= 1'b0;
			O_USB_CORE_RST      <= 1'b0;
			O_USB_KEEP_ATTACHED <= 1'b0;
			O_BANDGAP_EN        <= 1'b0;
			prdata_r            <= 32'h0;
			pslverr_r           <= 1'b0;
		end else begin
			O_WDOG_RST          <= rst_set;
			O_DELAY_START       <= O_WDOG_RST;
			O_USB_CORE_RST      <= usb_rst;
			O_USB_KEEP_ATTACHED <= I_USB_EN;
			O_BANDGAP_EN        <= (I_BROWNOUT_LEVEL_FUSE != `WARF_BROWNOUT_OFF) |
			                       I_COMPARATOR_BANDGAP_SELECT | I_ADC_EN;
			if (setup_ph) begin
				prdata_r  <= rd_word;
				pslverr_r <= ~mapped;
			end
		end
	end

	assign PREADY  = 1'b1;
	assign PSLVERR = pslverr_r & PSEL & PENABLE;
	assign PRDATA  = prdata_r;
	assign O_IRQ   = iflag_r & ien_eff;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_SRST);

	a_wdog_pulse_one: assert property (O_WDOG_RST |=> !O_WDOG_RST)
		else $error("watchdog reset pulse longer than one cycle");
	a_delay_after_pulse: assert property ($fell(O_WDOG_RST) |-> O_DELAY_START)
		else $error("delay start missing after reset pulse");
	a_usb_core_reset: assert property (usb_rst |=> O_USB_CORE_RST && O_USB_KEEP_ATTACHED)
		else $error("usb core reset not issued with usb kept attached");
	a_cause_top_zero: assert property (addr_hit(PADDR, `WARF_OFF_CAUSE) |-> rd_word[7:6] == 2'h0)
		else $error("reserved cause bits read nonzero");
	a_wdog_flag_set: assert property (O_WDOG_RST |=> cause_r[`WARF_BIT_WATCHDOG])
		else $error("watchdog reset flag not set");
	a_ext_flag_set: assert property (I_EXT_PIN_RST |=> cause_r[`WARF_BIT_EXTPIN])
		else $error("external reset flag not set");
	a_por_sticky: assert property ($fell(cause_r[0]) |-> $past(wr_cause && !PWDATA[0]))
		else $error("power-on flag cleared without a written zero");
	a_bandgap_on: assert property (!I_SRST |=> O_BANDGAP_EN == $past(I_ADC_EN | I_COMPARATOR_BANDGAP_SELECT |
		(I_BROWNOUT_LEVEL_FUSE != `WARF_BROWNOUT_OFF)))
		else $error("bandgap enable wrong");
	a_restart_zero: assert property (I_WDOG_RESTART |=> cnt_r == '0)
		else $error("restart did not zero the counter");
	a_irq_mode: assert property (expire && mode == warf_pkg::WARF_IRQ_MODE |=> iflag_r && !O_WDOG_RST)
		else $error("interrupt mode expiry wrong");
	a_fuse_lock: assert property (I_ALWAYS_ON_FUSE |-> ren_eff && !ien_eff)
		else $error("always-on fuse does not lock the mode");
	a_window_four: assert property (open_seq ##1 (!open_seq)[*4] |=> !in_win)
		else $error("change enable not cleared after four cycles");
	a_window_open: assert property (open_seq |=> in_win[*4])
		else $error("change window shorter than four cycles");
	a_psc_locked: assert property (wr_ctrl && !in_win |=> psc_r == $past(psc_r))
		else $error("prescaler changed outside the window");
	a_wdog_flag_ren: assert property (wdog_flag |-> ren_eff)
		else $error("reset enable low while watchdog flag set");

	// Flag clears are checked only when no event lands in the same cycle, since the set wins.
	a_brownout_flag_set: assert property (I_BROWNOUT_RST |=> cause_r[`WARF_BIT_BROWNOUT])
		else $error("brown-out reset flag not set");
	a_test_flag_set: assert property (I_TEST_PORT_RST |=> cause_r[`WARF_BIT_TESTPORT])
		else $error("test-port reset flag not set");
	a_usb_flag_set: assert property (usb_rst |=> cause_r[`WARF_BIT_USBCORE])
		else $error("usb core reset flag not set");
	a_ext_flag_clear: assert property (wr_cause && !PWDATA[`WARF_BIT_EXTPIN] && !I_EXT_PIN_RST
		|=> !cause_r[`WARF_BIT_EXTPIN])
		else $error("external reset flag not cleared by written zero");
	a_wdog_flag_clear: assert property (wr_cause && !PWDATA[`WARF_BIT_WATCHDOG] && !wdog_rst
		|=> !cause_r[`WARF_BIT_WATCHDOG])
		else $error("watchdog reset flag not cleared by written zero");
	a_por_clear: assert property (wr_cause && !PWDATA[`WARF_BIT_POWERON] |=> !cause_r[`WARF_BIT_POWERON])
		else $error("power-on flag not cleared by written zero");
	a_usb_no_core: assert property (!usb_rst |=> !O_USB_CORE_RST)
		else $error("usb core reset without its condition");
	a_keep_attached: assert property (!I_SRST |=> O_USB_KEEP_ATTACHED == $past(I_USB_EN))
		else $error("usb attach output does not follow enable");
	a_reset_mode: assert property (expire && mode == warf_pkg::WARF_RESET_MODE |=> O_WDOG_RST)
		else $error("reset mode expiry gave no reset");
	a_both_first_irq: assert property (expire && mode == warf_pkg::WARF_BOTH_MODE && !iflag_r
		|=> iflag_r && !O_WDOG_RST)
		else $error("combined mode first expiry wrong");
	a_both_then_reset: assert property (expire && mode == warf_pkg::WARF_BOTH_MODE && iflag_r |=> O_WDOG_RST)
		else $error("combined mode second expiry gave no reset");
	a_vector_to_reset: assert property (I_VECTOR_ACK && mode == warf_pkg::WARF_BOTH_MODE && !wr_ctrl
		|=> !ien_r)
		else $error("vector did not leave combined mode");
	a_irq_vector_clear: assert property (I_VECTOR_ACK && !irq_set |=> !iflag_r)
		else $error("vector did not clear interrupt flag");
	a_irq_write_clear: assert property (wr_ctrl && PWDATA[`WARF_BIT_IFLAG] && !irq_set |=> !iflag_r)
		else $error("written one did not clear interrupt flag");
	a_irq_wake: assert property (irq_set && ien_eff && !wr_ctrl && !I_VECTOR_ACK |=> O_IRQ)
		else $error("interrupt request not raised");
	a_tick_hold: assert property (!I_SRST && running && !I_OSC_TICK && !I_WDOG_RESTART
		|=> cnt_r == $past(cnt_r))
		else $error("counter moved without an oscillator tick");
	a_tick_advance: assert property (!I_SRST && running && I_OSC_TICK && !expire && !I_WDOG_RESTART
		|=> cnt_r == $past(cnt_r) + P_CNT_W'(1))
		else $error("counter did not advance on a tick");
	a_expire_zero: assert property (expire |=> cnt_r == '0)
		else $error("counter not zeroed at expiry");
	a_reserved_code: assert property (psc_r > `WARF_PSC_MAX
		|-> limit_m1 == P_CNT_W'((P_BASE_CYCLES << `WARF_PSC_MAX) - 1))
		else $error("reserved prescaler code not mapped to longest period");
	a_ren_lock: assert property (!in_win && ren_r |=> ren_r)
		else $error("reset enable cleared outside the window");
	a_ien_free: assert property (wr_ctrl && !I_ALWAYS_ON_FUSE |=> ien_r == $past(PWDATA[`WARF_BIT_IEN]))
		else $error("interrupt enable write not taken");
	a_timed_psc: assert property (timed_wr |=> psc_r == $past(psc_wr))
		else $error("timed write did not set the prescaler");
	a_open_needs_both: assert property (wr_ctrl && !in_win && !(PWDATA[`WARF_BIT_CHG] && PWDATA[`WARF_BIT_REN])
		|=> !in_win)
		else $error("window opened without both enable bits");
	a_fuse_no_irq: assert property (I_ALWAYS_ON_FUSE |-> !O_IRQ)
		else $error("interrupt raised under always-on fuse");
	a_wdog_stays_on: assert property (O_WDOG_RST |=> ##1 mode != warf_pkg::WARF_STOPPED)
		else $error("watchdog stopped after its own reset");
	a_delay_one: assert property (O_DELAY_START |=> !O_DELAY_START)
		else $error("delay start longer than one cycle");
	a_delay_only_after: assert property (O_DELAY_START |-> $past(O_WDOG_RST))
		else $error("delay start without a reset pulse");

	// ****************************************************************
	// Coverage.
	// ****************************************************************
	c_wdog_reset: cover property (O_WDOG_RST ##1 O_DELAY_START);
	c_irq_raised: cover property (irq_set ##1 O_IRQ);
	c_timed_change: cover property (open_seq ##[1:4] timed_wr);
	c_usb_reset: cover property (usb_rst);
	c_both_reset: cover property (rst_set && mode == warf_pkg::WARF_BOTH_MODE);

endmodule

// >>> testbench/watchdog_and_reset_flags_tb.sv
`timescale 1ns/1ps
`include "warf_map.svh"

module watchdog_and_reset_flags_tb;

	// ********************************************************************
	// Bench signals and design instance.
	// ********************************************************************
	// A small base count keeps every time-out short.
	localparam int NB = 4;
	logic        clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        tick;
	logic        restart;
	logic        vack;
	logic        fuse;
	logic [2:0]  bo_level;
	logic        cmp_bg;
	logic        adc;
	logic [3:0]  ev;
	logic        usb_en;
	logic        usb_crst;
	wire         prdy;
	wire         perr;
	wire  [31:0] prd;
	wire         rst_p;
	wire         dly;
	wire         ucr;
	wire         keep;
	wire         irq;
	wire         bg;
	int          fail_count;
	int          check_count;
	logic [31:0] rd;
	logic        er;
	int          k;
	int          n;
	int          pos [4];
	logic [3:0]  codes [3];

	warf_top #(.P_BASE_CYCLES(NB), .P_CNT_W(21)) warf_top_inst (
		.I_REF_CLK(clk), .I_SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PREADY(prdy), .PSLVERR(perr), .PRDATA(prd),
		.I_OSC_TICK(tick), .I_WDOG_RESTART(restart), .I_VECTOR_ACK(vack),
		.I_ALWAYS_ON_FUSE(fuse), .I_BROWNOUT_LEVEL_FUSE(bo_level), .I_COMPARATOR_BANDGAP_SELECT(cmp_bg),
		.I_ADC_EN(adc), .I_EXT_PIN_RST(ev[0]), .I_BROWNOUT_RST(ev[1]), .I_TEST_PORT_RST(ev[2]),
		.I_USB_EN(usb_en), .I_USB_CORE_RST_EN(usb_crst), .I_USB_BUS_RST(ev[3]),
		.O_WDOG_RST(rst_p), .O_DELAY_START(dly), .O_USB_CORE_RST(ucr),
		.O_USB_KEEP_ATTACHED(keep), .O_IRQ(irq), .O_BANDGAP_EN(bg)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ********************************************************************
	// Tasks.
	// ********************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read data is taken at the edge where pready is sampled, before the design updates.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int w = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			w++;
		end while (prdy !== 1'b1 && w < 16);
		rd = prd;
		er = perr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd & mask, exp);
	endtask

	// The opening write keeps the old prescaler, so a slip cannot shorten the time-out.
	task automatic setpsc(input logic [31:0] v);
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0018 | (v & 32'h0000_0027));
		apb(1'b1, `WARF_OFF_CTRL, v);
	endtask

	task automatic restart_run();
		@(posedge clk);
		restart <= 1'b1;
		tick    <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
	endtask

	task automatic wait_irq(input int lim);
		k = 0;
		while (irq !== 1'b1 && k < lim + 4) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	task automatic wait_rst(input int lim);
		k = 0;
		while (rst_p !== 1'b1 && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		check({31'h0, rst_p}, 32'h1);
		@(posedge clk);
		#1;
		check({30'h0, rst_p, dly}, 32'h1);
	endtask

	function automatic logic [31:0] enc(input logic [3:0] c);
		return {26'h0, c[3], 2'b00, c[2:0]};
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	initial begin
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		tick = 1'b0; restart = 1'b0; vack = 1'b0; fuse = 1'b0; bo_level = `WARF_BROWNOUT_OFF; cmp_bg = 1'b0;
		adc = 1'b0; ev = 4'h0; usb_en = 1'b1; usb_crst = 1'b1; fail_count = 0; check_count = 0;
		pos = '{`WARF_BIT_EXTPIN, `WARF_BIT_BROWNOUT, `WARF_BIT_TESTPORT, `WARF_BIT_USBCORE};
		codes = '{4'h1, 4'h2, 4'ha};
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h0000_0001);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
		apb(1'b0, 8'h0c, 32'h0000_0000);
		check({rd[30:0], er}, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			bo_level <= i[0] ? 3'h0 : `WARF_BROWNOUT_OFF;
			cmp_bg   <= i[1];
			adc  <= i[2];
			repeat (3) @(posedge clk);
			check({31'h0, bg}, {31'h0, (i != 0)});
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ev <= 4'h1 << i;
			@(posedge clk);
			ev <= 4'h0;
			#1;
			check({30'h0, ucr, keep}, {30'h0, (i == 3), 1'b1});
			rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h1 | (32'h1 << pos[i]));
			apb(1'b1, `WARF_OFF_CAUSE, 32'h3f & ~(32'h1 << pos[i]));
			rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h0000_0001);
		end
		@(posedge clk);
		usb_en <= 1'b0;
		ev     <= 4'h8;
		@(posedge clk);
		ev     <= 4'h0;
		#1;
		check({30'h0, ucr, keep}, 32'h0);
		apb(1'b1, `WARF_OFF_CAUSE, 32'h0000_0000);
		rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h0000_0000);
		// Interrupt mode, raise, clear by written one, clear by vector.
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0040);
		restart_run();
		wait_irq(NB);
		check({31'h0, (k >= NB && k <= NB + 2)}, 32'h1);
		@(posedge clk);
		tick <= 1'b0;
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_00c0);
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_00c0);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_0040);
		restart_run();
		wait_irq(NB);
		@(posedge clk);
		tick <= 1'b0;
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		#1;
		check({31'h0, irq}, 32'h0);
		restart_run();
		repeat (10) begin
			@(posedge clk);
			restart <= 1'b1;
			@(posedge clk);
			restart <= 1'b0;
		end
		#1;
		check({31'h0, irq}, 32'h0);
		@(posedge clk);
		tick <= 1'b0;
		rchk(`WARF_OFF_COUNT, 32'hffff_ffff, 32'h0000_0001);
		// Prescaler codes, a reserved one among them.
		for (int i = 0; i < 3; i++) begin
			setpsc(32'h40 | enc(codes[i]));
			rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h40 | enc(codes[i]));
			n = NB << ((codes[i] > 4'h9) ? 9 : codes[i]);
			restart_run();
			wait_irq(n);
			check({31'h0, (k >= n && k <= n + 2)}, 32'h1);
			@(posedge clk);
			tick <= 1'b0;
			apb(1'b1, `WARF_OFF_CTRL, 32'hc0 | enc(codes[i]));
		end
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0040);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h40 | enc(4'ha));
		apb(1'b1, `WARF_OFF_CTRL, 32'h18 | enc(4'ha));
		repeat (6) @(posedge clk);
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0040);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h48 | enc(4'ha));
		setpsc(32'h0000_0048);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_0048);
		// Combined mode: an unserviced interrupt is followed by a reset.
		restart_run();
		wait_irq(NB);
		check({30'h0, (k >= NB && k <= NB + 2), rst_p}, 32'h2);
		wait_rst(NB + 4);
		@(posedge clk);
		tick <= 1'b0;
		rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h0000_0008);
		rchk(`WARF_OFF_CTRL, 32'h0000_0008, 32'h0000_0008);
		setpsc(32'h0000_0000);
		rchk(`WARF_OFF_CTRL, 32'h0000_0008, 32'h0000_0008);
		apb(1'b1, `WARF_OFF_CAUSE, 32'h0000_0000);
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0080);
		setpsc(32'h0000_0000);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
		// Always-on fuse forces reset mode.
		@(posedge clk);
		fuse <= 1'b1;
		apb(1'b1, `WARF_OFF_CTRL, 32'h0000_0040);
		rchk(`WARF_OFF_CTRL, 32'h0000_0048, 32'h0000_0008);
		restart_run();
		wait_rst(NB + 4);
		@(posedge clk);
		tick <= 1'b0;
		fuse <= 1'b0;
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rchk(`WARF_OFF_CAUSE, 32'hffff_ffff, 32'h0000_0001);
		rchk(`WARF_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
		print_verdict();
	end

endmodule
